// [src/lpw_pkg.sv]
// Purpose: Shared constants and types for the latched position window monitor.
// Assumes: One clock (pclk), APB register access, logic cycle given by a strobe.
// Notes:   Register map, field positions, reset values and message codes live here.
// How it works
// - Activation rise captures position as reference
// - While active, delta is position minus reference
// - Window ok only when active and in margins
// - Delta output forced zero when not ok
// - Both margins are unsigned 32-bit magnitudes
// - Diag 0 none, 1 below negated margin
// - Diag 2 when delta above upper margin
// - Underflow message 0x40C0 with instance, position, reference
// - Overflow message 0x40C1 with instance, position, reference
// - Run code 1: in range, ok high
// - Run enable low gives stop code 2
// - Activation low gives safe code 3
// - Range failure gives error code 4, message
// - Acknowledge without pending error gives reset 5
// - Leave reset only when ack, activation low
// - Two options expose state and diag codes
// - Position input INT16/INT32/UINT16/UINT32 by configuration
// - Delta output signed 16 or 32 bits
package lpw_pkg;

  // Register byte offsets
  localparam logic [7:0] LPW_CTRL_OFF   = 8'h00;
  localparam logic [7:0] LPW_UPPER_OFF  = 8'h04;
  localparam logic [7:0] LPW_LOWER_OFF  = 8'h08;
  localparam logic [7:0] LPW_STATUS_OFF = 8'h0C;
  localparam logic [7:0] LPW_REF_OFF    = 8'h10;
  localparam logic [7:0] LPW_DELTA_OFF  = 8'h14;

  // Control field positions
  localparam int LPW_CTRL_EXP_STATE_BIT = 0;
  localparam int LPW_CTRL_EXP_DIAG_BIT  = 1;
  localparam int LPW_CTRL_FMT_LSB       = 2;
  localparam int LPW_CTRL_WIDE_BIT      = 4;

  // Status field positions
  localparam int LPW_STAT_DIAG_LSB = 4;
  localparam int LPW_STAT_OK_BIT   = 8;
  localparam int LPW_STAT_ERR_BIT  = 9;

  // Reset values
  localparam logic [31:0] LPW_CTRL_RESET   = 32'h0000_0010;
  localparam logic [31:0] LPW_MARGIN_RESET = 32'h0000_0000;

  // Diagnostic message identifiers
  localparam logic [15:0] LPW_MSG_UNDER = 16'h40C0;
  localparam logic [15:0] LPW_MSG_OVER  = 16'h40C1;

  // Reported codes
  localparam logic [2:0] LPW_CODE_RUN   = 3'h1;
  localparam logic [2:0] LPW_CODE_STOP  = 3'h2;
  localparam logic [2:0] LPW_CODE_SAFE  = 3'h3;
  localparam logic [2:0] LPW_CODE_ERROR = 3'h4;
  localparam logic [2:0] LPW_CODE_RESET = 3'h5;

  typedef enum logic [1:0] {
    LPW_DIAG_NONE  = 2'h0,
    LPW_DIAG_UNDER = 2'h1,
    LPW_DIAG_OVER  = 2'h2
  } lpw_diag_type;

  typedef enum logic [1:0] {
    LPW_FMT_INT32  = 2'h0,
    LPW_FMT_INT16  = 2'h1,
    LPW_FMT_UINT16 = 2'h2,
    LPW_FMT_UINT32 = 2'h3
  } lpw_fmt_type;

  // Gray codes along stop, safe, run, error, reset
  typedef enum logic [2:0] {
    LPW_ST_STOP  = 3'h0,
    LPW_ST_SAFE  = 3'h1,
    LPW_ST_RUN   = 3'h3,
    LPW_ST_ERROR = 3'h2,
    LPW_ST_RESET = 3'h6
  } lpw_state_type;

  typedef struct packed {
    logic        wide_delta;
    lpw_fmt_type pos_fmt;
    logic        expose_diag_code;
    logic        expose_state_code;
  } lpw_cfg_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] id;
    logic [15:0] instance_id;
    logic [31:0] position;
    logic [31:0] reference;
  } lpw_msg_type;

endpackage

// [src/lpw_delta_calc.sv]
// Purpose: Position widening, delta and margin comparison.
// Assumes: Pure combinational, same clock domain as the caller.
// Notes:   Comparison runs at 34 bits so negated margins never wrap.
module lpw_delta_calc
  import lpw_pkg::*;
(
  input  wire logic [31:0] position_raw,
  input  wire lpw_fmt_type pos_fmt,
  input  wire logic        wide_delta,
  input  wire logic [31:0] reference,
  input  wire logic [31:0] upper_margin_value,
  input  wire logic [31:0] lower_margin_value,
  output logic      [31:0] position_ext,
  output logic      [31:0] delta_full,
  output logic      [31:0] delta_sized,
  output logic             below,
  output logic             above
);

  logic signed [33:0] delta_wide;

  // Widen the raw input by its configured format
  always_comb begin
    unique case (pos_fmt)
      LPW_FMT_INT16:  position_ext = {{16{position_raw[15]}}, position_raw[15:0]};
      LPW_FMT_UINT16: position_ext = {16'h0000, position_raw[15:0]};
      default:        position_ext = position_raw;
    endcase
  end

  // Full precision difference; wraps like the 32-bit arithmetic it models
  assign delta_full = position_ext - reference;
  assign delta_wide = {{2{delta_full[31]}}, delta_full};

  // Margins are magnitudes, zero-extended before use
  assign below = delta_wide < -$signed({2'b00, lower_margin_value});
  assign above = delta_wide > $signed({2'b00, upper_margin_value});

  // Narrow output keeps the low half, sign-extended for a clean read
  assign delta_sized = wide_delta ? delta_full
                     : {{16{delta_full[15]}}, delta_full[15:0]};

endmodule

// [src/lpw_monitor.sv]
// Purpose: Latched position window monitor with APB configuration.
// Assumes: All functional inputs come from logic on pclk; strobe marks a cycle.
// Notes:   Ok, delta and fault change only on a strobe; the message valid lasts one clock; the APB slave never waits.
//
// Design decisions made here: register access over APB and the address map.
module lpw_monitor
  import lpw_pkg::*;
#(
  parameter logic [15:0] INSTANCE_ID = 16'h0001 // Arbitrary instance tag
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cycle_strobe,
  input  wire logic        sync_reset,
  input  wire logic        increment_watch_request,
  input  wire logic [31:0] position_in,
  input  wire logic        block_run_enable,
  input  wire logic        fault_acknowledge,
  output logic             window_ok,
  output logic      [31:0] position_delta,
  output logic             fault_out,
  output logic      [2:0]  state_image,
  output logic      [1:0]  diag_image,
  output lpw_msg_type      diag_msg
);

  lpw_cfg_type   cfg_q;
  logic [31:0]   upper_q;
  logic [31:0]   lower_q;
  lpw_state_type state_q;
  lpw_state_type state_d;
  logic [31:0]   ref_q;
  logic          req_prev_q;
  logic          ok_q;
  logic [31:0]   delta_q;
  logic          fault_q;
  lpw_diag_type  diag_q;
  lpw_diag_type  diag_d;
  lpw_msg_type   msg_q;
  logic [31:0]   pos_ext;
  logic [31:0]   delta_full;
  logic [31:0]   delta_sized;
  logic          below;
  logic          above;
  logic          req_rise;
  logic          apb_wr;
  logic [31:0]   ctrl_word;
  logic [31:0]   status_word;

  // Map internal encoding to the reported code
  function automatic logic [2:0] code_of(input lpw_state_type s);
    unique case (s)
      LPW_ST_RUN:   code_of = LPW_CODE_RUN;
      LPW_ST_SAFE:  code_of = LPW_CODE_SAFE;
      LPW_ST_ERROR: code_of = LPW_CODE_ERROR;
      LPW_ST_RESET: code_of = LPW_CODE_RESET;
      default:      code_of = LPW_CODE_STOP;
    endcase
  endfunction

  // Address decode for the error answer; the read mux decodes the same offsets in its own case
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == LPW_CTRL_OFF) || (a == LPW_UPPER_OFF) || (a == LPW_LOWER_OFF)
          || (a == LPW_STATUS_OFF) || (a == LPW_REF_OFF) || (a == LPW_DELTA_OFF);
  endfunction

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  lpw_delta_calc u_calc (
    .position_raw       (position_in),
    .pos_fmt            (cfg_q.pos_fmt),
    .wide_delta         (cfg_q.wide_delta),
    .reference          (ref_q),
    .upper_margin_value (upper_q),
    .lower_margin_value (lower_q),
    .position_ext       (pos_ext),
    .delta_full         (delta_full),
    .delta_sized        (delta_sized),
    .below              (below),
    .above              (above)
  );

  // APB slave answers in the access cycle itself
  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;
  assign pslverr = psel & penable & ~mapped(paddr);

  assign ctrl_word = {27'h000_0000, cfg_q.wide_delta, cfg_q.pos_fmt,
                      cfg_q.expose_diag_code, cfg_q.expose_state_code};

  // Status mirrors the internal view, independent of exposure options
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[2:0] = code_of(state_q);
    status_word[LPW_STAT_DIAG_LSB +: 2] = diag_q;
    status_word[LPW_STAT_OK_BIT] = ok_q;
    status_word[LPW_STAT_ERR_BIT] = fault_q;
  end

  // Read mux; unmapped reads return zero alongside pslverr
  always_comb begin
    unique case (paddr)
      LPW_CTRL_OFF:   prdata = ctrl_word;
      LPW_UPPER_OFF:  prdata = upper_q;
      LPW_LOWER_OFF:  prdata = lower_q;
      LPW_STATUS_OFF: prdata = status_word;
      LPW_REF_OFF:    prdata = ref_q;
      LPW_DELTA_OFF:  prdata = delta_q;
      default:        prdata = 32'h0000_0000;
    endcase
  end

  // Configuration register; reserved bits drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= lpw_cfg_type'(LPW_CTRL_RESET[4:0]);
    end else if (apb_wr && paddr == LPW_CTRL_OFF) begin
      cfg_q <= lpw_cfg_type'(merge(ctrl_word, pwdata, pstrb));
    end
  end

  // Margins held as plain unsigned magnitudes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_q <= LPW_MARGIN_RESET;
      lower_q <= LPW_MARGIN_RESET;
    end else if (apb_wr) begin
      if (paddr == LPW_UPPER_OFF) begin
        upper_q <= merge(upper_q, pwdata, pstrb);
      end
      if (paddr == LPW_LOWER_OFF) begin
        lower_q <= merge(lower_q, pwdata, pstrb);
      end
    end
  end

  // Edge seen between two strobes, not between two clocks
  assign req_rise = increment_watch_request & ~req_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_prev_q <= 1'b0;
    end else if (cycle_strobe) begin
      req_prev_q <= sync_reset ? 1'b0 : increment_watch_request;
    end
  end

  // Next state; run enable low overrides everything, even an error
  always_comb begin
    state_d = state_q;
    diag_d  = diag_q;
    if (sync_reset || !block_run_enable) begin
      state_d = LPW_ST_STOP;
      diag_d  = LPW_DIAG_NONE;
    end else begin
      unique case (state_q)
        LPW_ST_STOP: begin
          state_d = LPW_ST_SAFE;
        end
        LPW_ST_SAFE: begin
          if (req_rise) begin
            state_d = LPW_ST_RUN;
          end
        end
        LPW_ST_RUN: begin
          if (!increment_watch_request) begin
            state_d = LPW_ST_SAFE;
          end else if (below) begin
            state_d = LPW_ST_ERROR;
            diag_d  = LPW_DIAG_UNDER;
          end else if (above) begin
            state_d = LPW_ST_ERROR;
            diag_d  = LPW_DIAG_OVER;
          end
        end
        LPW_ST_ERROR: begin
          // A still-violated window counts as a pending error
          if (fault_acknowledge && !(increment_watch_request && (below || above))) begin
            state_d = LPW_ST_RESET;
            diag_d  = LPW_DIAG_NONE;
          end
        end
        LPW_ST_RESET: begin
          if (!fault_acknowledge && !increment_watch_request) begin
            state_d = LPW_ST_SAFE;
          end
        end
        default: begin
          state_d = LPW_ST_STOP;
          diag_d  = LPW_DIAG_NONE;
        end
      endcase
    end
  end

  // State and diagnostic code advance once per logic cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LPW_ST_STOP;
      diag_q  <= LPW_DIAG_NONE;
    end else if (cycle_strobe) begin
      state_q <= state_d;
      diag_q  <= diag_d;
    end
  end

  // Reference capture on the activation rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 32'h0000_0000;
    end else if (cycle_strobe && !sync_reset && state_q == LPW_ST_SAFE
                 && block_run_enable && req_rise) begin
      ref_q <= pos_ext;
    end
  end

  // Outputs follow the state being entered, so they match the code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ok_q    <= 1'b0;
      delta_q <= 32'h0000_0000;
      fault_q <= 1'b0;
    end else if (cycle_strobe) begin
      ok_q    <= (state_d == LPW_ST_RUN);
      fault_q <= (state_d == LPW_ST_ERROR);
      if (state_d == LPW_ST_RUN) begin
        // Capture cycle is forced to zero, since ref_q still holds the old reference
        delta_q <= (state_q == LPW_ST_RUN) ? delta_sized : 32'h0000_0000;
      end else begin
        delta_q <= 32'h0000_0000;
      end
    end
  end

  // One message pulse on entry to error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_q <= '0;
    end else begin
      msg_q.valid <= cycle_strobe && state_q == LPW_ST_RUN && state_d == LPW_ST_ERROR;
      if (cycle_strobe && state_q == LPW_ST_RUN && state_d == LPW_ST_ERROR) begin
        msg_q.id          <= below ? LPW_MSG_UNDER : LPW_MSG_OVER;
        msg_q.instance_id <= INSTANCE_ID;
        msg_q.position    <= pos_ext;
        msg_q.reference   <= ref_q;
      end
    end
  end

  assign window_ok      = ok_q;
  assign position_delta = delta_q;
  assign fault_out      = fault_q;
  assign diag_msg       = msg_q;
  // Codes appear on the image ports only when the option maps them
  assign state_image = cfg_q.expose_state_code ? code_of(state_q) : 3'h0;
  assign diag_image  = cfg_q.expose_diag_code ? diag_q : LPW_DIAG_NONE;

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      (cycle_strobe && !sync_reset && block_run_enable && state_q == LPW_ST_SAFE
       && req_rise) |=> (ref_q == $past(pos_ext) && state_q == LPW_ST_RUN);
  endproperty
  a_capture: assert property (p_capture) else $error("reference not captured");

  property p_delta_zero;
    @(posedge pclk) disable iff (!presetn)
      !window_ok |-> position_delta == 32'h0000_0000;
  endproperty
  a_delta_zero: assert property (p_delta_zero) else $error("delta not zero");

  property p_ok_run;
    @(posedge pclk) disable iff (!presetn)
      window_ok |-> (state_q == LPW_ST_RUN && !fault_out);
  endproperty
  a_ok_run: assert property (p_ok_run) else $error("ok outside run");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      (cycle_strobe && !block_run_enable)
      |=> state_q == LPW_ST_STOP && (state_image == 3'h0 || state_image == LPW_CODE_STOP)
          && !fault_out && !window_ok;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not entered");

  property p_safe;
    @(posedge pclk) disable iff (!presetn)
      (cycle_strobe && !sync_reset && block_run_enable && state_q == LPW_ST_RUN
       && !increment_watch_request) |=> state_q == LPW_ST_SAFE && !window_ok;
  endproperty
  a_safe: assert property (p_safe) else $error("safe not entered");

  property p_error;
    @(posedge pclk) disable iff (!presetn)
      (cycle_strobe && !sync_reset && block_run_enable && state_q == LPW_ST_RUN
       && increment_watch_request && (below || above))
      |=> fault_out && diag_msg.valid ##1 !diag_msg.valid;
  endproperty
  a_error: assert property (p_error) else $error("error not raised");

  property p_msg_id;
    @(posedge pclk) disable iff (!presetn)
      diag_msg.valid |-> diag_msg.id == ((diag_q == LPW_DIAG_UNDER) ? LPW_MSG_UNDER
                                                                   : LPW_MSG_OVER);
  endproperty
  a_msg_id: assert property (p_msg_id) else $error("wrong message id");

  property p_reset_hold;
    @(posedge pclk) disable iff (!presetn)
      (cycle_strobe && !sync_reset && block_run_enable && state_q == LPW_ST_RESET
       && (fault_acknowledge || increment_watch_request)) |=> state_q == LPW_ST_RESET;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset left early");

  property p_diag_hidden;
    @(posedge pclk) disable iff (!presetn)
      !cfg_q.expose_diag_code |-> diag_image == LPW_DIAG_NONE;
  endproperty
  a_diag_hidden: assert property (p_diag_hidden) else $error("diag leaked");

  // Acknowledge with no pending violation must leave error for reset
  property p_ack_reset;
    @(posedge pclk) disable iff (!presetn)
      (cycle_strobe && !sync_reset && block_run_enable && state_q == LPW_ST_ERROR
       && fault_acknowledge && !(increment_watch_request && (below || above)))
      |=> state_q == LPW_ST_RESET && !fault_out && !window_ok;
  endproperty
  a_ack_reset: assert property (p_ack_reset) else $error("reset not entered");

  property p_sync_stop;
    @(posedge pclk) disable iff (!presetn)
      (cycle_strobe && sync_reset)
      |=> state_q == LPW_ST_STOP && !window_ok && !fault_out
          && position_delta == 32'h0000_0000;
  endproperty
  a_sync_stop: assert property (p_sync_stop) else $error("sync reset ignored");

endmodule

// [verification/lpw_group_model.sv]
// Purpose: Group logic and position source facing the window monitor.
// Assumes: One pclk domain; the bench asks for one logic cycle at a time through go.
// Notes:   Level inputs change only with the strobe; position is inverted between strobes, so the monitor must sample on it.
module lpw_group_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        req_run,
  input  wire logic        req_act,
  input  wire logic        req_ack,
  input  wire logic        req_srst,
  input  wire logic [31:0] req_pos,
  output logic             cycle_strobe,
  output logic             sync_reset,
  output logic             increment_watch_request,
  output logic      [31:0] position_in,
  output logic             block_run_enable,
  output logic             fault_acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] pos_q;

  // One strobe per request; levels are held until the next request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_strobe            <= 1'b0;
      sync_reset              <= 1'b0;
      increment_watch_request <= 1'b0;
      block_run_enable        <= 1'b0;
      fault_acknowledge       <= 1'b0;
      pos_q                   <= 32'h0000_0000;
    end else begin
      cycle_strobe <= go;
      if (go) begin
        sync_reset              <= req_srst;
        increment_watch_request <= req_act;
        block_run_enable        <= req_run;
        fault_acknowledge       <= req_ack;
        pos_q                   <= req_pos;
      end
    end
  end

  // Off-strobe value is inverted so sampling between strobes is caught
  assign position_in = cycle_strobe ? pos_q : ~pos_q;
endmodule

// [verification/tb.sv]
// Purpose: Self-checking bench for the latched position window monitor.
// Assumes: APB master tasks and group model steps; zero-wait slave is not relied on.
// Notes:   Margins are small so boundaries sit 100 and 50 counts from the reference.
`define CHK(nm, ex, got) \
  begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lpw_pkg::*;
  localparam logic [15:0] INST = 16'h0A5C; // Arbitrary instance tag
  localparam logic [31:0] UP   = 32'h0000_0064;
  localparam logic [31:0] LO   = 32'h0000_0032;
  localparam logic [31:0] P0   = 32'h0000_03E8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        go, r_run, r_act, r_ack, r_srst, strobe, srst, act, run, ack;
  logic        window_ok, fault_out, err;
  logic [31:0] r_pos, position_in, position_delta;
  logic [2:0]  state_image;
  logic [1:0]  diag_image;
  lpw_msg_type diag_msg;
  int          miscompares, n_compared;

  lpw_monitor #(.INSTANCE_ID(INST)) lpw_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cycle_strobe(strobe), .sync_reset(srst),
    .increment_watch_request(act), .position_in(position_in), .block_run_enable(run),
    .fault_acknowledge(ack), .window_ok(window_ok), .position_delta(position_delta),
    .fault_out(fault_out), .state_image(state_image), .diag_image(diag_image),
    .diag_msg(diag_msg));

  lpw_group_model lpw_group_model_inst (
    .pclk(pclk), .presetn(presetn), .go(go), .req_run(r_run), .req_act(r_act),
    .req_ack(r_ack), .req_srst(r_srst), .req_pos(r_pos), .cycle_strobe(strobe),
    .sync_reset(srst), .increment_watch_request(act), .position_in(position_in),
    .block_run_enable(run), .fault_acknowledge(ack));

  // Clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends when pready is high; otherwise only the watchdog ends it
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One logic cycle; returns once the strobe edge updates have landed
  task automatic step(input logic rn, ac, ak, sr, input logic [31:0] p);
    @(posedge pclk);
    go     <= 1'b1;
    r_run  <= rn;
    r_act  <= ac;
    r_ack  <= ak;
    r_srst <= sr;
    r_pos  <= p;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  task automatic chk(input logic [2:0] st, input logic ok, input logic [31:0] d,
                     input logic f, input logic [1:0] dg);
    `CHK("state", st, state_image)
    `CHK("window_ok", ok, window_ok)
    `CHK("delta", d, position_delta)
    `CHK("fault", f, fault_out)
    `CHK("diag", dg, diag_image)
  endtask

  // Message must pulse exactly once and carry instance, position, reference
  task automatic msgchk(input logic [15:0] id, input logic [31:0] p, r);
    int n;
    n = 0;
    repeat (3) begin
      if (diag_msg.valid === 1'b1) n++;
      @(posedge pclk);
      #1;
    end
    `CHK("msg_pulses", 1, n)
    `CHK("msg_id", id, diag_msg.id)
    `CHK("msg_inst", INST, diag_msg.instance_id)
    `CHK("msg_pos", p, diag_msg.position)
    `CHK("msg_ref", r, diag_msg.reference)
  endtask

  task automatic summarize();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    summarize();
  end

  initial begin
    {psel, penable, pwrite, go, r_run, r_act, r_ack, r_srst} = '0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    r_pos       = 32'h0000_0000;
    miscompares = 0;
    n_compared  = 0;
    presetn     = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, LPW_CTRL_OFF, 32'h0);
    `CHK("ctrl_reset", LPW_CTRL_RESET, rd)
    apb(1'b0, LPW_UPPER_OFF, 32'h0);
    `CHK("upper_reset", LPW_MARGIN_RESET, rd)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    apb(1'b1, LPW_UPPER_OFF, UP);
    apb(1'b1, LPW_LOWER_OFF, LO);
    apb(1'b1, LPW_CTRL_OFF, 32'h0000_0013);
    step(1, 0, 0, 0, P0);
    chk(LPW_CODE_SAFE, 0, 0, 0, 0);
    step(1, 1, 0, 0, P0);
    chk(LPW_CODE_RUN, 1, 0, 0, 0);
    // The reference register is read-only; a write must not disturb it
    apb(1'b1, LPW_REF_OFF, 32'hFFFF_FFFF);
    apb(1'b0, LPW_REF_OFF, 32'h0);
    `CHK("reference", P0, rd)
    step(1, 1, 0, 0, P0 + UP);
    chk(LPW_CODE_RUN, 1, UP, 0, 0);
    apb(1'b0, LPW_DELTA_OFF, 32'h0);
    `CHK("delta_reg", UP, rd)
    step(1, 1, 0, 0, P0 - LO);
    chk(LPW_CODE_RUN, 1, 32'h0 - LO, 0, 0);
    step(1, 1, 0, 0, P0 - LO - 1);
    chk(LPW_CODE_ERROR, 0, 0, 1, LPW_DIAG_UNDER);
    msgchk(LPW_MSG_UNDER, P0 - LO - 1, P0);
    apb(1'b0, LPW_STATUS_OFF, 32'h0);
    `CHK("status", 32'h0000_0214, rd)
    step(1, 0, 1, 0, P0);
    chk(LPW_CODE_RESET, 0, 0, 0, 0);
    step(1, 0, 1, 0, P0);
    chk(LPW_CODE_RESET, 0, 0, 0, 0);
    step(1, 0, 0, 0, P0);
    chk(LPW_CODE_SAFE, 0, 0, 0, 0);
    step(1, 1, 0, 0, 32'h0);
    chk(LPW_CODE_RUN, 1, 0, 0, 0);
    step(1, 1, 0, 0, UP + 1);
    chk(LPW_CODE_ERROR, 0, 0, 1, LPW_DIAG_OVER);
    msgchk(LPW_MSG_OVER, UP + 1, 32'h0);
    step(0, 1, 0, 0, 32'h0);
    chk(LPW_CODE_STOP, 0, 0, 0, LPW_DIAG_NONE);
    step(1, 1, 0, 0, 32'h0);
    chk(LPW_CODE_SAFE, 0, 0, 0, 0);
    step(1, 0, 0, 0, 32'h0);
    step(1, 1, 0, 0, 32'h0);
    chk(LPW_CODE_RUN, 1, 0, 0, 0);
    step(1, 1, 0, 1, 32'h0);
    chk(LPW_CODE_STOP, 0, 0, 0, 0);
    // Signed 16-bit position and delta, both codes exposed
    apb(1'b1, LPW_CTRL_OFF, 32'h0000_0007);
    step(1, 0, 0, 0, 32'h0);
    step(1, 1, 0, 0, 32'h0);
    step(1, 1, 0, 0, 32'h0000_FFF0);
    chk(LPW_CODE_RUN, 1, 32'hFFFF_FFF0, 0, 0);
    // Same raw word as INT32 is far out of window; codes hidden
    apb(1'b1, LPW_CTRL_OFF, 32'h0000_0010);
    step(1, 1, 0, 0, 32'h0000_FFF0);
    chk(3'h0, 0, 0, 1, 2'h0);
    // Unsigned 16-bit drops the upper half, so the reference shows only the low word
    apb(1'b1, LPW_CTRL_OFF, 32'h0000_001B);
    step(0, 0, 0, 0, 32'h0);
    step(1, 0, 0, 0, 32'h0);
    step(1, 1, 0, 0, 32'h0001_FFF0);
    apb(1'b0, LPW_REF_OFF, 32'h0);
    `CHK("ref_uint16", 32'h0000_FFF0, rd)
    step(1, 1, 0, 0, 32'hFFFF_FFF5);
    chk(LPW_CODE_RUN, 1, 32'h0000_0005, 0, 0);
    // Unsigned 32-bit keeps the upper half, so the window is left
    apb(1'b1, LPW_CTRL_OFF, 32'h0000_001F);
    step(1, 1, 0, 0, 32'h0001_FFF0);
    chk(LPW_CODE_ERROR, 0, 0, 1, LPW_DIAG_OVER);
    msgchk(LPW_MSG_OVER, 32'h0001_FFF0, 32'h0000_FFF0);
    summarize();
  end
endmodule
